// File: common/rcbp_map.svh
`ifndef RCBP_MAP_SVH
`define RCBP_MAP_SVH
// Bus widths
`define RCBP_ADDR_W 4
`define RCBP_DATA_W 4
`define RCBP_DEPTH 16
// Control register holding the freeze and clear bits
`define RCBP_CTRL_ADDR 4'hd
`define RCBP_FREEZE_BIT 0
`define RCBP_CLEAR_BIT 1
// Reset value of every storage location
`define RCBP_LOC_RST 4'h0
`endif

// File: common/rcbp_pkg.sv
package rcbp_pkg;
  // Bus cycle in progress
  typedef enum logic [1:0] {
    rcbp_idle,
    rcbp_read,
    rcbp_write
  } rcbp_cycle_t;
endpackage : rcbp_pkg

// File: src/rcbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module rcbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin side
  input wire logic [W-1:0] pin,
  // Clock domain side
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Shift chain
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new value per bit once the later stages agree
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= RST;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          q[i] <= s2_q[i];
        end
      end
    end
  end
endmodule : rcbp_sync
`default_nettype wire

// File: src/rcbp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcbp_map.svh"
// What this block does
// - Address and bus select pass straight through while the latch strobe is high.
// - Latch strobe falling captures address and select; held while it stays low.
// - Write strobe leading edge stores data into the addressed location.
// - While read strobe is low, addressed location drives the data lines.
// - Access allowed only with power-good select high and bus select low.
// - Power-good select low means standby; bus accesses are ignored.
// - Power-good select falling clears the freeze and clear control bits.
// - Data lines float unless a selected read is in progress.
// - The 4-bit address picks one of sixteen storage locations.
module rcbp_port #(
  parameter int AW = `RCBP_ADDR_W,
  parameter int DW = `RCBP_DATA_W,
  parameter int DEPTH = `RCBP_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host bus pins
  input wire logic addr_latch,
  input wire logic [AW-1:0] nibble_address_lines,
  input wire logic bus_select_n,
  input wire logic power_good_select,
  input wire logic rd_n,
  input wire logic wr_n,
  // Data pins, split into three signals
  input wire logic [DW-1:0] nibble_data_in,
  output logic [DW-1:0] nibble_data_out,
  output logic nibble_data_oe,
  // Control bits seen by the timekeeping core
  output logic freeze_bit,
  output logic clear_bit
);
  localparam int SW = AW + 5;
  localparam logic [AW-1:0] CTRL = `RCBP_CTRL_ADDR;

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [DW-1:0] din_s;
  logic ale_s;
  logic sel_n_s;
  logic pg_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [AW-1:0] addr_in_s;
  logic [AW-1:0] addr_lat_q;
  logic sel_n_lat_q;
  logic [AW-1:0] addr_eff;
  logic sel_n_eff;
  logic selected;
  logic pg_q;
  logic wr_n_q;
  logic [DW-1:0] mem_q [DEPTH];
  rcbp_pkg::rcbp_cycle_t cyc_q;
  logic strobe_clash;
  logic wr_start;
  logic rd_req;
  logic pg_fall;

  // Pins resynchronised into the clock domain; strobes reset inactive
  assign pins_raw = {addr_latch, bus_select_n, power_good_select, rd_n, wr_n,
                     nibble_address_lines};
  rcbp_sync #(.W(SW), .RST({1'b1, 1'b1, 1'b0, 1'b1, 1'b1, {AW{1'b0}}})) u_sync_ctl (
    .clk(clk),
    .rstn(rstn),
    .pin(pins_raw),
    .q(pins_s)
  );
  rcbp_sync #(.W(DW), .RST({DW{1'b0}})) u_sync_dat (
    .clk(clk),
    .rstn(rstn),
    .pin(nibble_data_in),
    .q(din_s)
  );
  assign ale_s = pins_s[SW-1];
  assign sel_n_s = pins_s[SW-2];
  assign pg_s = pins_s[SW-3];
  assign rd_n_s = pins_s[SW-4];
  assign wr_n_s = pins_s[SW-5];
  assign addr_in_s = pins_s[AW-1:0];

  // Address and select latch follows while strobe high, freezes while low
  // Uses the synced strobe so it stays in step with the synced address and select
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_lat_q <= '0;
      sel_n_lat_q <= 1'b1;
    end
    else if (ale_s)
    begin
      addr_lat_q <= addr_in_s;
      sel_n_lat_q <= sel_n_s;
    end
  end

  // Transparent path while strobe is high; a tied-high strobe stays transparent
  assign addr_eff = ale_s ? addr_in_s : addr_lat_q;
  assign sel_n_eff = ale_s ? sel_n_s : sel_n_lat_q;
  assign selected = pg_s && !sel_n_eff;

  // Both strobes low is an illegal host cycle; neither access is taken then
  assign strobe_clash = !rd_n_s && !wr_n_s;
  // A write is taken once, on the first cycle the synced strobe is seen low
  assign wr_start = selected && wr_n_q && !wr_n_s && !strobe_clash;
  // A read is served only for a selected host with the write strobe idle
  assign rd_req = selected && !rd_n_s && !strobe_clash;
  // Standby entry, seen as the synced power-good level dropping
  assign pg_fall = pg_q && !pg_s;

  // Edge history for write strobe and power-good select
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_n_q <= 1'b1;
      pg_q <= 1'b0;
    end
    else
    begin
      wr_n_q <= wr_n_s;
      pg_q <= pg_s;
    end
  end

  // Storage: write on strobe leading edge; standby entry clears control bits
  // A write never meets the standby clear, since writes need power-good high
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= `RCBP_LOC_RST;
      end
    end
    else
    begin
      if (wr_start)
      begin
        mem_q[addr_eff] <= din_s;
      end
      if (pg_fall)
      begin
        mem_q[CTRL][`RCBP_FREEZE_BIT] <= 1'b0;
        mem_q[CTRL][`RCBP_CLEAR_BIT] <= 1'b0;
      end
    end
  end

  // Track the bus cycle for the data driver
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_q <= rcbp_pkg::rcbp_idle;
    end
    else
    begin
      case (cyc_q)
        rcbp_pkg::rcbp_idle:
        begin
          if (rd_req)
          begin
            cyc_q <= rcbp_pkg::rcbp_read;
          end
          else if (selected && !wr_n_s && rd_n_s)
          begin
            cyc_q <= rcbp_pkg::rcbp_write;
          end
        end
        rcbp_pkg::rcbp_read:
        begin
          if (rd_n_s || !selected)
          begin
            cyc_q <= rcbp_pkg::rcbp_idle;
          end
        end
        rcbp_pkg::rcbp_write:
        begin
          if (wr_n_s || !selected)
          begin
            cyc_q <= rcbp_pkg::rcbp_idle;
          end
        end
        default:
        begin
          cyc_q <= rcbp_pkg::rcbp_idle;
        end
      endcase
    end
  end

  // Read data register follows the addressed location during a read
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nibble_data_out <= '0;
    end
    else if (rd_req)
    begin
      nibble_data_out <= mem_q[addr_eff];
    end
  end

  // Drive only during a selected read, float in standby or deselected
  assign nibble_data_oe = (cyc_q == rcbp_pkg::rcbp_read) && selected && !rd_n_s;

  // Control bits to the core
  assign freeze_bit = mem_q[CTRL][`RCBP_FREEZE_BIT];
  assign clear_bit = mem_q[CTRL][`RCBP_CLEAR_BIT];
endmodule : rcbp_port
`default_nettype wire

// File: tb/rcbp_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the host pins and the outputs of the port
module rcbp_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host pins
  input wire logic addr_latch,
  input wire logic bus_select_n,
  input wire logic power_good_select,
  input wire logic rd_n,
  input wire logic wr_n,
  // Port outputs
  input wire logic nibble_data_oe,
  input wire logic freeze_bit,
  input wire logic clear_bit
);
  logic sel_lat_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Select level as last seen through the latch
  always_ff @(posedge clk)
  begin
    if (addr_latch)
    begin
      sel_lat_q <= bus_select_n;
    end
  end
  standby_no_drive_a: assert property (!power_good_select [*8] |-> !nibble_data_oe)
    else $error("data driven in standby");
  idle_no_drive_a: assert property (rd_n [*8] |-> !nibble_data_oe)
    else $error("data driven without read");
  write_no_drive_a: assert property (!wr_n [*8] |-> !nibble_data_oe)
    else $error("data driven during write");
  read_drives_a: assert property ((!rd_n && power_good_select && !bus_select_n && addr_latch) [*8]
    |-> nibble_data_oe)
    else $error("selected read not driven");
  desel_no_drive_a: assert property ((bus_select_n && addr_latch) [*8] |-> !nibble_data_oe)
    else $error("data driven while deselected");
  latch_hold_a: assert property ((!addr_latch && sel_lat_q && !rd_n) [*8] |-> !nibble_data_oe)
    else $error("latched deselect ignored");
  standby_clear_a: assert property ($fell(power_good_select)
    |-> ##[3:8] (!freeze_bit && !clear_bit))
    else $error("control bits kept in standby");
  bits_by_write_a: assert property (($rose(freeze_bit) || $rose(clear_bit))
    |-> (!wr_n && power_good_select))
    else $error("control bit set without write");
endmodule : rcbp_chk
bind rcbp_port rcbp_chk chk_u (
  .clk(clk),
  .rstn(rstn),
  .addr_latch(addr_latch),
  .bus_select_n(bus_select_n),
  .power_good_select(power_good_select),
  .rd_n(rd_n),
  .wr_n(wr_n),
  .nibble_data_oe(nibble_data_oe),
  .freeze_bit(freeze_bit),
  .clear_bit(clear_bit)
);
`default_nettype wire

// File: tb/rcbp_host_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// Resolves the shared data lines between host and port
module rcbp_host_mdl (
  // Clock
  input wire logic clk,
  // Drive enables of both sides
  input wire logic host_oe,
  input wire logic dev_oe,
  // Data offered by both sides
  input wire logic [3:0] host_d,
  input wire logic [3:0] dev_d,
  // Resolved data lines
  output logic [3:0] bus
);
  logic [3:0] last_q = 4'h0;
  // Released lines show a pattern that changes every cycle
  always_comb bus = dev_oe ? dev_d : host_oe ? host_d : ~last_q;
  always_ff @(posedge clk) last_q <= bus;
endmodule : rcbp_host_mdl
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcbp_map.svh"
`define CHK(x, y) begin n_checks++; if ((x) !== (y)) begin n_errors++; \
  $display("[FAIL] %0t %h %h", $time, x, y); end end
module testbench;
  logic clk = 0, rstn = 0, ale = 1, cs_n = 1, pg = 1, rd_n = 1, wr_n = 1, hoe = 0, oe, frz, clr;
  logic [3:0] a = 4'h0, hd = 4'h0, bus, dout;
  logic [3:0] m [16];
  int seed = 87158, n_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  rcbp_port dut_u (.clk(clk), .rstn(rstn), .addr_latch(ale), .nibble_address_lines(a),
    .bus_select_n(cs_n), .power_good_select(pg), .rd_n(rd_n), .wr_n(wr_n),
    .nibble_data_in(bus), .nibble_data_out(dout), .nibble_data_oe(oe), .freeze_bit(frz),
    .clear_bit(clr));
  rcbp_host_mdl host_u (.clk(clk), .host_oe(hoe), .dev_oe(oe), .host_d(hd), .dev_d(dout),
    .bus(bus));
  // Expected control bits carried by a control location value, clear above freeze
  function automatic logic [1:0] ctrl_exp(input logic [3:0] loc);
    return {loc[`RCBP_CLEAR_BIT], loc[`RCBP_FREEZE_BIT]};
  endfunction : ctrl_exp
  // Prints the counts and the verdict
  task finish_test;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // One bus access; mux latches address and select, then scrambles the pins
  task acc(input logic w, input logic [3:0] ad, d, input logic sn, mux, drv);
    int i;
    @(negedge clk);
    a = ad; hd = d; cs_n = sn; ale = 1; hoe = w;
    repeat (6) @(negedge clk);
    if (mux)
    begin
      ale = 0;
      @(negedge clk);
      a = ~ad;
      cs_n = ~sn;
    end
    repeat (6) @(negedge clk);
    if (w) wr_n = 0; else rd_n = 0;
    for (i = 0; i < 12 && oe !== 1'b1; i++) @(negedge clk);
    `CHK(oe, drv)
    if (drv) `CHK(bus, d)
    if (drv && i == 12) finish_test;
    repeat (8) @(negedge clk);
    wr_n = 1; rd_n = 1;
    repeat (8) @(negedge clk);
    hoe = 0; ale = 1;
  endtask : acc
  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 16; k++)
    begin
      m[k] = 4'($random(seed));
      acc(1, 4'(k), m[k], 0, k[0], 0);
    end
    `CHK({clr, frz}, ctrl_exp(m[`RCBP_CTRL_ADDR]))
    for (int k = 0; k < 16; k++) acc(0, 4'(k), m[k], 0, ~k[0], 1);
    acc(1, 4'h5, ~m[5], 1, 0, 0);
    acc(0, 4'h5, 4'h0, 1, 1, 0);
    pg = 0;
    acc(1, 4'h6, ~m[6], 0, 0, 0);
    acc(0, 4'h6, 4'h0, 0, 0, 0);
    pg = 1;
    acc(0, 4'h5, m[5], 0, 1, 1);
    acc(0, 4'h6, m[6], 0, 0, 1);
    acc(1, `RCBP_CTRL_ADDR, 4'h3, 0, 0, 0);
    `CHK({clr, frz}, ctrl_exp(4'h3))
    pg = 0;
    repeat (8) @(negedge clk);
    `CHK({clr, frz}, 2'h0)
    finish_test;
  end
endmodule : testbench
`default_nettype wire
